// ===== rtl/gdio_pkg.sv
// package: register map, reset values and carrier types for the gpio port
package gdio_pkg;
    localparam int          PORT_W           = 8;
    localparam logic [11:0] OFF_DIRECTION    = 12'h000;
    localparam logic [11:0] OFF_OUTPUT_VALUE = 12'h004;
    localparam logic [11:0] OFF_PIN_INPUT    = 12'h008;
    localparam logic [11:0] OFF_SPECIAL_FUNC = 12'h00C;
    localparam logic [11:0] OFF_EXT_IRQ      = 12'h010;
    localparam logic [11:0] OFF_EXT_FLAG     = 12'h014;
    localparam int          PUD_BIT          = 2;
    localparam logic [7:0]  RESET_BYTE       = 8'h00;
    localparam logic        RESET_BIT        = 1'b0;
    localparam int          SYNC_STAGES      = 2;
    localparam int          SYNC_LAT_CYCLES  = SYNC_STAGES;

    typedef struct packed {
        logic [7:0] drive_value;
        logic [7:0] drive_oe_n;
        logic [7:0] pullup_en;
        logic [7:0] input_clamp;
    } gdio_pad_ctrl_t;

    typedef enum logic [1:0] {
        GDIO_ST_IDLE   = 2'b00,
        GDIO_ST_ACCESS = 2'b01
    } gdio_bus_state_t;
endpackage : gdio_pkg

// ===== rtl/gdio_sync.sv
// two-flop synchroniser for a vector of pad inputs
`timescale 1ns/1ps
module gdio_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1_q;

    // stage1 is an edge-triggered flop on the falling edge, not a transparent latch;
    // trade-off: only half a period to settle metastability
    always_ff @(negedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1_q <= '0;
        end else if (clk_en) begin
            stage1_q <= async_in;
        end
    end

    // stage1 feeds only sync_out: no other logic may look at it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_out <= '0;
        end else if (clk_en) begin
            sync_out <= stage1_q;
        end
    end
endmodule : gdio_sync

// ===== rtl/gdio_port.sv
// gpio port: direction, output value, pull-up, input sync, sleep clamp
//
// What this block does
// - direction bit one enables the pin driver; zero makes the pin an input.
// - input with output value one turns pull-up on unless globally disabled.
// - global pull-up disable turns off every pull-up regardless of other bits.
// - output pin drives high for value one, low for value zero.
// - reset puts all pins in high impedance at once, clock or not.
// - input register shows each pin's synchronised level in any direction.
// - pin input is sampled in a falling-edge flop stage then into the input register.
// - external pin change reaches input register after a bounded delay.
// - software-written value reaches the input register two cycles after the write.
// - deep sleep modes clamp each pin's digital input to ground.
// - clamp is skipped for pins enabled as external interrupt inputs.
// - clamp release on a held-high sensing pin sets its interrupt flag.
// - pull-ups stay disabled while reset is asserted.
// - inputs stay unclamped in reset, active and idle modes.
// - strobes are shared per port; clock, sleep request and pull-up disable by all.
// - input register is read-only; direction and output value are RW.
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module gdio_port #(
    parameter int WIDTH = gdio_pkg::PORT_W
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   clk_en,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   deep_sleep,
    input  wire logic [WIDTH-1:0]       pin_in,
    output logic      [WIDTH-1:0]       pin_out,
    output logic      [WIDTH-1:0]       pin_oe_n,
    output logic      [WIDTH-1:0]       pin_pullup_en,
    output logic      [WIDTH-1:0]       pin_input_clamp,
    output gdio_pkg::gdio_pad_ctrl_t    pad_ctrl
);
    logic [WIDTH-1:0] port_direction_q;
    logic [WIDTH-1:0] port_output_value_q;
    logic [WIDTH-1:0] ext_irq_enable_q;
    logic [WIDTH-1:0] ext_irq_flag_q;
    logic             global_pullup_disable_q;
    logic [WIDTH-1:0] port_pin_input_q;
    logic [WIDTH-1:0] sleep_sync;
    logic [WIDTH-1:0] pin_sync;
    logic [WIDTH-1:0] clamped_level;
    logic [WIDTH-1:0] clamp_prev_q;
    logic [WIDTH-1:0] clamp_prev2_q;
    logic [WIDTH-1:0] pullup_d;
    logic [WIDTH-1:0] clamp_d;
    logic [WIDTH-1:0] flag_set;
    logic             sleep_q;
    logic             sleep_s1_q;
    logic             wr_en;

    function automatic logic [31:0] pad32(input logic [WIDTH-1:0] v);
        pad32 = {{(32-WIDTH){1'b0}}, v};
    endfunction : pad32

    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] off);
        hit = (a == off);
    endfunction : hit

    // zero-wait apb: every access completes in its first access cycle
    assign wr_en = psel && penable && pwrite;

    // sleep request comes from another controller: synchronise it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_s1_q <= gdio_pkg::RESET_BIT;
            sleep_q    <= gdio_pkg::RESET_BIT;
        end else if (clk_en) begin
            sleep_s1_q <= deep_sleep;
            sleep_q    <= sleep_s1_q;
        end
    end

    // per-pin clamp; interrupt-enabled pins stay live in sleep
    assign clamp_d = sleep_q ? ~ext_irq_enable_q : '0;

    // clamped pins read as ground ahead of the synchroniser
    assign clamped_level = pin_in & ~pin_input_clamp;

    gdio_sync #(
        .WIDTH    (WIDTH)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .clk_en   (clk_en),
        .async_in (clamped_level),
        .sync_out (pin_sync)
    );

    // second synchroniser stage is the input register itself
    assign port_pin_input_q = pin_sync;

    // register writes; strobes are shared by all pins of the port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_direction_q        <= gdio_pkg::RESET_BYTE;
            port_output_value_q     <= gdio_pkg::RESET_BYTE;
            ext_irq_enable_q        <= gdio_pkg::RESET_BYTE;
            global_pullup_disable_q <= gdio_pkg::RESET_BIT;
        end else if (clk_en && wr_en) begin
            if (hit(paddr, gdio_pkg::OFF_DIRECTION)) begin
                port_direction_q <= pwdata[WIDTH-1:0];
            end
            if (hit(paddr, gdio_pkg::OFF_OUTPUT_VALUE)) begin
                port_output_value_q <= pwdata[WIDTH-1:0];
            end
            if (hit(paddr, gdio_pkg::OFF_SPECIAL_FUNC)) begin
                global_pullup_disable_q <= pwdata[gdio_pkg::PUD_BIT];
            end
            if (hit(paddr, gdio_pkg::OFF_EXT_IRQ)) begin
                ext_irq_enable_q <= pwdata[WIDTH-1:0];
            end
        end
    end

    // sensed change when the clamp lets go of a pin held high; clamp
    // history is delayed so the released level has crossed the synchroniser
    assign flag_set = clamp_prev2_q & ~pin_input_clamp & pin_sync;

    // flag clears by writing one; a set in the same cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_irq_flag_q <= gdio_pkg::RESET_BYTE;
            clamp_prev_q   <= gdio_pkg::RESET_BYTE;
            clamp_prev2_q  <= gdio_pkg::RESET_BYTE;
        end else if (clk_en) begin
            clamp_prev_q  <= pin_input_clamp;
            clamp_prev2_q <= clamp_prev_q;
            if (wr_en && hit(paddr, gdio_pkg::OFF_EXT_FLAG)) begin
                ext_irq_flag_q <= (ext_irq_flag_q & ~pwdata[WIDTH-1:0])
                                  | flag_set;
            end else begin
                ext_irq_flag_q <= ext_irq_flag_q | flag_set;
            end
        end
    end

    // pull-up only for inputs with value one and no global disable
    assign pullup_d = ~port_direction_q & port_output_value_q
                      & {WIDTH{~global_pullup_disable_q}};

    // pad outputs; async reset gives tri-state and no pull-up at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out         <= '0;
            pin_oe_n        <= '1;
            pin_pullup_en   <= '0;
            pin_input_clamp <= '0;
        end else if (clk_en) begin
            pin_out         <= port_output_value_q;
            pin_oe_n        <= ~port_direction_q;
            pin_pullup_en   <= pullup_d;
            pin_input_clamp <= clamp_d;
        end
    end

    // same pad state bundled for a pad ring that takes the struct
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_ctrl <= '{drive_value: '0, drive_oe_n: '1,
                          pullup_en: '0, input_clamp: '0};
        end else if (clk_en) begin
            pad_ctrl <= '{drive_value: 8'(port_output_value_q),
                          drive_oe_n:  8'(~port_direction_q),
                          pullup_en:   8'(pullup_d),
                          input_clamp: 8'(clamp_d)};
        end
    end

    // read data; input register ignores writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    gdio_pkg::OFF_DIRECTION:
                        prdata <= pad32(port_direction_q);
                    gdio_pkg::OFF_OUTPUT_VALUE:
                        prdata <= pad32(port_output_value_q);
                    gdio_pkg::OFF_PIN_INPUT:
                        prdata <= pad32(port_pin_input_q);
                    gdio_pkg::OFF_SPECIAL_FUNC:
                        prdata <= 32'(global_pullup_disable_q)
                                  << gdio_pkg::PUD_BIT;
                    gdio_pkg::OFF_EXT_IRQ:
                        prdata <= pad32(ext_irq_enable_q);
                    gdio_pkg::OFF_EXT_FLAG:
                        prdata <= pad32(ext_irq_flag_q);
                    default:
                        prdata <= 32'h0000_0000;
                endcase
            end
            if (psel && !penable && !hit(paddr, gdio_pkg::OFF_DIRECTION)
                && !hit(paddr, gdio_pkg::OFF_OUTPUT_VALUE)
                && !hit(paddr, gdio_pkg::OFF_PIN_INPUT)
                && !hit(paddr, gdio_pkg::OFF_SPECIAL_FUNC)
                && !hit(paddr, gdio_pkg::OFF_EXT_IRQ)
                && !hit(paddr, gdio_pkg::OFF_EXT_FLAG)) begin
                pslverr <= 1'b1;
            end
        end
    end

endmodule : gdio_port

// ===== verif/gdio_pins_model.sv
// board model: resolves each pad from driver, pull-up and external source
`timescale 1ns/1ps
module gdio_pins_model (
    input  wire logic       pclk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe_n,
    input  wire logic [7:0] pin_pullup_en,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_level,
    output logic      [7:0] pin_in
);
    // a floating pad toggles so it never settles into a lucky match
    logic [7:0] float_q = 8'h5A;
    always @(posedge pclk) float_q <= ~float_q;
    assign pin_in = (~pin_oe_n & pin_out)
                  | (pin_oe_n & pin_pullup_en)
                  | (pin_oe_n & ext_en & ext_level)
                  | (pin_oe_n & ~pin_pullup_en & ~ext_en & float_q);
endmodule : gdio_pins_model

// ===== verif/gdio_port_chk.sv
// checker: port-level relations of the gpio port
`timescale 1ns/1ps
module gdio_port_chk #(parameter int WIDTH = 8) (
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [11:0]      paddr,
    input wire logic [31:0]      pwdata,
    input wire logic             pready,
    input wire logic             pslverr,
    input wire logic             deep_sleep,
    input wire logic [WIDTH-1:0] pin_out,
    input wire logic [WIDTH-1:0] pin_oe_n,
    input wire logic [WIDTH-1:0] pin_pullup_en,
    input wire logic [WIDTH-1:0] pin_input_clamp
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    dir_to_oe_a: assert property (
        pready && pwrite && paddr == 12'h000
        |-> ##2 pin_oe_n == ~$past(pwdata[WIDTH-1:0], 2))
        else $error("driver enable does not follow direction");
    val_to_out_a: assert property (
        pready && pwrite && paddr == 12'h004
        |-> ##2 pin_out == $past(pwdata[WIDTH-1:0], 2))
        else $error("drive value does not follow output value");
    pull_drive_a: assert property ((pin_pullup_en & ~pin_oe_n) == '0)
        else $error("pull-up on a driven pin");
    pull_value_a: assert property ((pin_pullup_en & ~pin_out) == '0)
        else $error("pull-up with output value zero");
    reset_tri_a: assert property ($rose(presetn)
        |-> pin_oe_n == '1 && pin_pullup_en == '0)
        else $error("pins not tri-stated out of reset");
    awake_clamp_a: assert property ((!deep_sleep)[*5]
        |-> pin_input_clamp == '0)
        else $error("input clamped while awake");
    ready_time_a: assert property (psel && !penable |=> pready)
        else $error("no answer in access cycle");
    ready_only_a: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    ro_noerr_a: assert property (pready && paddr == 12'h008
        |-> !pslverr)
        else $error("error on input register access");
    sleep_only_a: assert property (
        pin_input_clamp != '0 |-> $past(deep_sleep, 3))
        else $error("input clamped without sleep request");
endmodule : gdio_port_chk
bind gdio_port gdio_port_chk #(.WIDTH(WIDTH)) u_chk (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .deep_sleep, .pin_out, .pin_oe_n, .pin_pullup_en, .pin_input_clamp);

// ===== verif/tb.sv
// testbench: apb traffic, pad configuration, input read-back, sleep clamp
`timescale 1ns/1ps
module tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic deep_sleep = 0, clk_en = 1, pready, pslverr, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0] pin_in, pin_out, pin_oe_n, pin_pullup_en, pin_input_clamp;
    logic [7:0] ext_en, ext_level = 8'h00;
    gdio_pkg::gdio_pad_ctrl_t pad_ctrl;
    int errors = 0, checked = 0, seed = 72104, dir, val, pm, pu, i;
    // the board drives only pads that nothing else holds
    assign ext_en = pin_oe_n & ~pin_pullup_en;
    gdio_port u_gdio_port (.pclk, .presetn, .clk_en, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .deep_sleep,
        .pin_in, .pin_out, .pin_oe_n, .pin_pullup_en, .pin_input_clamp,
        .pad_ctrl);
    gdio_pins_model u_gdio_pins_model (.pclk, .pin_out, .pin_oe_n,
        .pin_pullup_en, .ext_en, .ext_level, .pin_in);
    initial forever #2 pclk = ~pclk;
    task report_and_stop;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    task chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            errors++;
            $display("ERROR %0t: saw %h expected %h", $time, s, e);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask : apb
    task rchk(input logic [11:0] a, input logic [31:0] e);
        apb(0, a, $random(seed));
        chk(rd, e);
    endtask : rchk
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        chk(pin_oe_n, 8'hFF);
        chk(pin_pullup_en, 8'h00);
        for (i = 0; i < 5; i++) rchk(12'(i * 4 + (i > 1) * 4), 0);
        rchk(12'h020, 0);
        chk(er, 1'b1);
        $display("test reset done");
        for (i = 0; i < 24; i++) begin
            dir = $random(seed) & 255;
            val = $random(seed) & 255;
            pm = ($random(seed) & 1) ? 0 : 255;
            ext_level <= 8'($random(seed));
            apb(1, 12'h000, dir);
            apb(1, 12'h004, val);
            apb(1, 12'h00C, pm ? 0 : 4);
            apb(1, 12'h008, $random(seed));
            chk(er, 1'b0);
            repeat (4) @(posedge pclk);
            pu = ~dir & val & pm & 255;
            chk(pin_oe_n, ~dir & 255);
            chk(pin_out, val);
            chk(pin_pullup_en, pu);
            chk(pad_ctrl, {val[7:0], ~dir[7:0], pu[7:0], 8'h00});
            rchk(12'h000, dir);
            rchk(12'h004, val);
            rchk(12'h008, (dir & val) | pu | (~dir & ~pu & ext_level));
        end
        $display("test config done");
        apb(1, 12'h010, 8'h0F);
        apb(1, 12'h000, 0);
        apb(1, 12'h00C, 0);
        ext_level <= 8'hFF;
        clk_en <= 0;
        deep_sleep <= 1;
        repeat (8) @(posedge pclk);
        chk(pin_input_clamp, 8'h00);
        clk_en <= 1;
        repeat (8) @(posedge pclk);
        chk(pin_input_clamp, 8'hF0);
        rchk(12'h008, 8'h0F);
        deep_sleep <= 0;
        repeat (8) @(posedge pclk);
        chk(pin_input_clamp, 8'h00);
        rchk(12'h014, 8'hF0);
        apb(1, 12'h014, 8'hFF);
        rchk(12'h014, 0);
        $display("test sleep done");
        apb(1, 12'h004, 8'hFF);
        apb(1, 12'h000, 8'h0F);
        repeat (2) @(posedge pclk);
        chk(pin_pullup_en, 8'hF0);
        presetn <= 0;
        #1;
        chk(pin_oe_n, 8'hFF);
        chk(pin_pullup_en, 8'h00);
        repeat (4) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        rchk(12'h000, 0);
        rchk(12'h004, 0);
        $display("test reset again done");
        report_and_stop;
    end
    initial begin
        #20000;
        $display("ERROR %0t: watchdog expired", $time);
        errors++;
        report_and_stop;
    end
endmodule : tb
